// [logic/gpio_bank.sv]
// General-purpose I/O bank with status and software-ready indicators
// How it works
// - Each line picks input, output, alternate, I2C or peripheral
// - Input lines report the sampled pad level
// - Output lines drive and read back written value
// - Alternate lines follow internal logic, not software
// - Ten primary lines always usable as GPIO
// - Extra lines GPIO only when peripheral unused
// - Primary lines may select I2C function
// - Any input line can raise an interrupt
// - Only lines 1,4,5,8 can wake
// - Output mode drives high and low actively
// - Line 1 resets to network status indicator
// - Searching: 1 s period, 0.5 s high
// - Registered: 3 s period, 0.3 s high
// - Off low, call active high
// - Ready indicator low until boot done
// - Ready indicator high while commands accepted
// - Line 8 resets to software-ready indicator
// - Temperature alarm drives selected line high
module gpio_bank
    import gpio_bank_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Pads
    input  wire logic [LINES-1:0]         padIn,
    output logic      [LINES-1:0]         padOut,
    output logic      [LINES-1:0]         padOe,
    // Configuration
    input  wire logic [LINES-1:0]         cfgWrite,
    input  wire line_mode_t               cfgMode,
    input  wire logic [LINES-1:0]         outWrite,
    input  wire logic [LINES-1:0]         outValue,
    input  wire trig_t                    trigKind,
    input  wire logic [LINES-1:0]         irqEnable,
    input  wire logic [LINES-1:0]         irqClear,
    input  wire logic                     sleeping,
    // Internal functions
    input  wire logic [LINES-NUM_PRIMARY-1:0] peripheralBusy,
    input  wire logic [LINES-NUM_PRIMARY-1:0] peripheralOut,
    input  wire logic [LINES-NUM_PRIMARY-1:0] peripheralOe,
    input  wire logic [NUM_PRIMARY-1:0]   i2cOut,
    input  wire logic [NUM_PRIMARY-1:0]   i2cOe,
    input  wire net_state_t               netState,
    input  wire logic                     bootDone,
    input  wire logic                     commandReady,
    input  wire logic                     temperatureMonitorCommand,
    input  wire logic                     tempMaxReached,
    input  wire logic [4:0]               tempLineSel,
    // Status
    output logic      [LINES-1:0]         readValue,
    output logic      [LINES-1:0]         irqPending,
    output logic                          wakeRequest,
    output line_mode_t                    modeOf [LINES]
);
    import gpio_bank_pkg::*;

    logic [LINES-1:0] padSync;
    logic [LINES-1:0] padPrev_reg;
    logic [LINES-1:0] driven_reg;
    logic [LINES-1:0] edgeHit;
    logic [LINES-1:0] isInput;
    logic [LINES-1:0] tempForce;
    logic             statusLevel;
    logic             readyLevel;
    line_mode_t       mode_reg [LINES];

    // Is a mode legal for a given line
    function automatic logic mode_ok(input int idx, input line_mode_t m, input logic busy);
        logic ok;
        ok = 1'b0;
        if (idx < NUM_PRIMARY) begin
            ok = (m == MODE_INPUT) || (m == MODE_OUTPUT) || (m == MODE_I2C)
                 || (m == MODE_ALTERNATE && (idx == STATUS_LINE || idx == READY_LINE));
        end else begin
            ok = (m == MODE_PERIPHERAL) || (!busy && (m == MODE_INPUT || m == MODE_OUTPUT));
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise pads before sampling or detecting edges
    line_sync #(.WIDTH(LINES)) uSync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn (padIn),
        .syncOut (padSync)
    );

    status_blinker uBlink (
        .clk       (clk),
        .reset     (reset),
        .netState  (netState),
        .indicator (statusLevel)
    );

    // Ready indicator: low until boot done, then follows readiness
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readyLevel <= 1'b0;
        end else begin
            readyLevel <= bootDone && commandReady;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-line mode, output latch and interrupt state
    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : gLine
            localparam int PIDX = (i >= NUM_PRIMARY) ? i - NUM_PRIMARY : 0;
            logic busy;
            assign busy = (i >= NUM_PRIMARY) ? peripheralBusy[PIDX] : 1'b0;

            // Exactly one mode per line; illegal requests ignored
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    if (i == STATUS_LINE || i == READY_LINE) begin
                        mode_reg[i] <= MODE_ALTERNATE;
                    end else if (i >= NUM_PRIMARY) begin
                        mode_reg[i] <= MODE_PERIPHERAL;
                    end else begin
                        mode_reg[i] <= MODE_INPUT;
                    end
                end else if (cfgWrite[i] && mode_ok(i, cfgMode, busy)) begin
                    mode_reg[i] <= cfgMode;
                end
            end

            // Software output value
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    driven_reg[i] <= 1'b0;
                end else if (outWrite[i]) begin
                    driven_reg[i] <= outValue[i];
                end
            end

            // Pad drive selection; push-pull so enable covers both levels
            always_comb begin
                padOut[i] = 1'b0;
                padOe[i]  = 1'b0;
                case (mode_reg[i])
                    MODE_OUTPUT: begin
                        padOut[i] = driven_reg[i];
                        padOe[i]  = 1'b1;
                    end
                    MODE_ALTERNATE: begin
                        padOut[i] = (i == STATUS_LINE) ? statusLevel : readyLevel;
                        padOe[i]  = 1'b1;
                    end
                    MODE_I2C: begin
                        padOut[i] = (i < NUM_PRIMARY) ? i2cOut[i % NUM_PRIMARY] : 1'b0;
                        padOe[i]  = (i < NUM_PRIMARY) ? i2cOe[i % NUM_PRIMARY] : 1'b0;
                    end
                    MODE_PERIPHERAL: begin
                        padOut[i] = (i >= NUM_PRIMARY) ? peripheralOut[PIDX] : 1'b0;
                        padOe[i]  = (i >= NUM_PRIMARY) ? peripheralOe[PIDX] : 1'b0;
                    end
                    default: begin
                    end
                endcase
                if (tempForce[i]) begin
                    padOut[i] = 1'b1;
                    padOe[i]  = 1'b1;
                end
            end

            assign isInput[i] = (mode_reg[i] == MODE_INPUT);
            assign tempForce[i] = temperatureMonitorCommand && tempMaxReached
                                  && (tempLineSel == 5'(i));

            // Trigger detection on the synchronised level
            always_comb begin
                case (trigKind)
                    TRIG_RISE: edgeHit[i] = padSync[i] && !padPrev_reg[i];
                    TRIG_FALL: edgeHit[i] = !padSync[i] && padPrev_reg[i];
                    TRIG_BOTH: edgeHit[i] = padSync[i] != padPrev_reg[i];
                    default:   edgeHit[i] = padSync[i];
                endcase
            end

            // Sticky pending flag; a new event beats a clear
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    irqPending[i] <= 1'b0;
                end else if (isInput[i] && irqEnable[i] && edgeHit[i]) begin
                    irqPending[i] <= 1'b1;
                end else if (irqClear[i]) begin
                    irqPending[i] <= 1'b0;
                end
            end

            assign modeOf[i] = mode_reg[i];
        end
    endgenerate

    // Previous synchronised level for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            padPrev_reg <= '0;
        end else begin
            padPrev_reg <= padSync;
        end
    end

    // Read value: inputs show the pad, outputs show the driven value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readValue <= '0;
        end else begin
            for (int k = 0; k < LINES; k++) begin
                readValue[k] <= (mode_reg[k] == MODE_OUTPUT) ? driven_reg[k]
                                                               : padSync[k];
            end
        end
    end

    // Wake only from the permitted lines while asleep
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wakeRequest <= 1'b0;
        end else begin
            wakeRequest <= sleeping
                && |(irqPending[NUM_PRIMARY-1:0] & WAKE_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_armed(int n);
        isInput[n] && irqEnable[n] && edgeHit[n];
    endsequence

    property p_irq_set;
        @(posedge clk) disable iff (reset) s_armed(5) |=> irqPending[5];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("input event not latched");

    property p_out_drive;
        @(posedge clk) disable iff (reset)
            (mode_reg[2] == MODE_OUTPUT && !tempForce[2]) |-> (padOe[2] && padOut[2] == driven_reg[2]);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("output line not driven");

    property p_input_float;
        @(posedge clk) disable iff (reset)
            (mode_reg[3] == MODE_INPUT && !tempForce[3]) |-> !padOe[3];
    endproperty
    a_input_float: assert property (p_input_float) else $error("input line driven");

    property p_ready_low;
        @(posedge clk) disable iff (reset) !bootDone |=> !readyLevel;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready before boot");

    property p_ready_high;
        @(posedge clk) disable iff (reset) (bootDone && commandReady) |=> readyLevel;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready not raised");

    property p_temp;
        @(posedge clk) disable iff (reset)
            tempForce[3] |-> (padOe[3] && padOut[3]);
    endproperty
    a_temp: assert property (p_temp) else $error("alarm line not high");

    property p_wake_mask;
        @(posedge clk) disable iff (reset)
            !(|(irqPending[NUM_PRIMARY-1:0] & WAKE_MASK)) |=> !wakeRequest;
    endproperty
    a_wake_mask: assert property (p_wake_mask) else $error("wake from other line");

    property p_status_alt;
        @(posedge clk) disable iff (reset)
            (mode_reg[0] == MODE_ALTERNATE && !tempForce[0]) |-> padOut[0] == statusLevel;
    endproperty
    a_status_alt: assert property (p_status_alt) else $error("status line wrong");
endmodule

// [logic/gpio_bank_pkg.sv]
// Package: constants, modes and timing for the general-purpose I/O bank
package gpio_bank_pkg;
    localparam int    NUM_PRIMARY   = 10;
    localparam int    NUM_EXTRA     = 17;
    localparam int    NUM_LINES     = NUM_PRIMARY + NUM_EXTRA;
    localparam int    CLK_HZ        = 25000000;
    // Blink time base in milliseconds and its length in clock cycles
    localparam int    TICK_MS       = 100;
    localparam int    TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    // Status indicator timing in milliseconds, as printed
    localparam int    FAST_PERIOD_MS = 1000;
    localparam int    FAST_HIGH_MS   = 500;
    localparam int    SLOW_PERIOD_MS = 3000;
    localparam int    SLOW_HIGH_MS   = 300;
    localparam int    FAST_PERIOD_TK = FAST_PERIOD_MS / TICK_MS;
    localparam int    FAST_HIGH_TK   = FAST_HIGH_MS / TICK_MS;
    localparam int    SLOW_PERIOD_TK = SLOW_PERIOD_MS / TICK_MS;
    localparam int    SLOW_HIGH_TK   = SLOW_HIGH_MS / TICK_MS;
    // Line indices (zero based) of the indicator and wake-capable lines
    localparam int    STATUS_LINE   = 0;
    localparam int    READY_LINE    = 7;
    localparam logic [NUM_PRIMARY-1:0] WAKE_MASK = 10'h099;
    // Per-line function select
    typedef enum logic [2:0] {
        MODE_INPUT,
        MODE_OUTPUT,
        MODE_ALTERNATE,
        MODE_I2C,
        MODE_PERIPHERAL
    } line_mode_t;
    // Network state driving the status indicator
    typedef enum logic [2:0] {
        NET_OFF,
        NET_SEARCH,
        NET_REGISTERED,
        NET_CALL
    } net_state_t;
    // Interrupt trigger kinds
    typedef enum logic [1:0] {
        TRIG_RISE,
        TRIG_FALL,
        TRIG_BOTH,
        TRIG_HIGH
    } trig_t;
endpackage

// [logic/line_sync.sv]
// Two-stage synchroniser for a vector of pad inputs
module line_sync #(
    parameter int WIDTH = 27
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule

// [logic/status_blinker.sv]
// Network status indicator pattern generator on a counted time base
module status_blinker
    import gpio_bank_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire net_state_t netState,
    output logic            indicator
);
    logic [$clog2(TICK_CYCLES)-1:0] tickCount_reg;
    logic [4:0]                     phase_reg;
    logic                           tick;
    logic [4:0]                     periodTk;
    logic [4:0]                     highTk;
    net_state_t                     lastState_reg;

    assign tick = (tickCount_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

    // Time base counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tickCount_reg <= '0;
        end else if (tick) begin
            tickCount_reg <= '0;
        end else begin
            tickCount_reg <= tickCount_reg + 1'b1;
        end
    end

    // Pattern select: periods are whole multiples of the tick
    always_comb begin
        periodTk = 5'(FAST_PERIOD_TK);
        highTk   = 5'(FAST_HIGH_TK);
        if (netState == NET_REGISTERED) begin
            periodTk = 5'(SLOW_PERIOD_TK);
            highTk   = 5'(SLOW_HIGH_TK);
        end
    end

    // Phase restarts when the state changes so a new pattern starts clean
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg     <= '0;
            lastState_reg <= NET_OFF;
        end else begin
            lastState_reg <= netState;
            if (netState != lastState_reg) begin
                phase_reg <= '0;
            end else if (tick) begin
                phase_reg <= (phase_reg >= periodTk - 5'd1) ? 5'd0 : phase_reg + 5'd1;
            end
        end
    end

    // Output level per network state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            indicator <= 1'b0;
        end else begin
            case (netState)
                NET_OFF:  indicator <= 1'b0;
                NET_CALL: indicator <= 1'b1;
                default:  indicator <= (phase_reg < highTk);
            endcase
        end
    end
endmodule

// [verification/pad_board_model.sv]
// Board-side model that drives, or leaves floating, the pads of the bank
module pad_board_model
    import gpio_bank_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [NUM_LINES-1:0] padOut,
    input  wire logic [NUM_LINES-1:0] padOe,
    input  wire logic [NUM_LINES-1:0] drvEn,
    input  wire logic [NUM_LINES-1:0] drvVal,
    output logic      [NUM_LINES-1:0] padIn
);
    logic [NUM_LINES-1:0] flipReg;
    logic [NUM_LINES-1:0] boardEn;

    ////////////////////////////////////////////////////////////////////////////
    // Floating pads have no pull, so they toggle rather than keep a stale level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flipReg <= '0;
        end else begin
            flipReg <= ~flipReg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Board keeps off every pad during power-up so no strap line is pulled high
    assign boardEn = reset ? '0 : drvEn;
    // Device drive wins wherever its output enable is high
    assign padIn = (padOe & padOut) | (~padOe & boardEn & drvVal)
                 | (~padOe & ~boardEn & flipReg);
endmodule

// [verification/gpio_bank_bench.sv]
// Self-checking bench for the general-purpose I/O bank
module gpio_bank_bench;
    import gpio_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int         line;
        line_mode_t mode;
        logic       val;
        logic       pad;
        logic       busy;
        line_mode_t expMode;
        logic       expOe;
        logic       expOut;
        logic       expRd;
    } row_t;

    logic clk, reset, sleeping, bootDone, commandReady;
    logic temperatureMonitorCommand, tempMaxReached;
    logic [4:0] tempLineSel;
    logic [NUM_LINES-1:0] padIn, padOut, padOe, cfgWrite, outWrite, outValue;
    logic [NUM_LINES-1:0] irqEnable, irqClear, readValue, irqPending, drvEn, drvVal;
    logic [NUM_EXTRA-1:0] peripheralBusy, peripheralOut, peripheralOe;
    logic [NUM_PRIMARY-1:0] i2cOut, i2cOe;
    logic wakeRequest;
    line_mode_t cfgMode;
    line_mode_t modeOf [NUM_LINES];
    trig_t trigKind;
    net_state_t netState;
    int fail_count = 0;
    int tests_run = 0;

    // Ordinary cases: configure one line, then compare mode and pad behaviour
    row_t rows [9] = '{
        '{2, MODE_OUTPUT, 1'b1, 1'b0, 1'b1, MODE_OUTPUT, 1'b1, 1'b1, 1'b1},
        '{2, MODE_OUTPUT, 1'b0, 1'b1, 1'b1, MODE_OUTPUT, 1'b1, 1'b0, 1'b0},
        '{2, MODE_ALTERNATE, 1'b1, 1'b1, 1'b1, MODE_OUTPUT, 1'b1, 1'b1, 1'b1},
        '{3, MODE_INPUT, 1'b0, 1'b1, 1'b1, MODE_INPUT, 1'b0, 1'b0, 1'b1},
        '{3, MODE_INPUT, 1'b1, 1'b0, 1'b1, MODE_INPUT, 1'b0, 1'b0, 1'b0},
        '{4, MODE_I2C, 1'b0, 1'b0, 1'b1, MODE_I2C, 1'b1, 1'b1, 1'b1},
        '{10, MODE_INPUT, 1'b0, 1'b1, 1'b1, MODE_PERIPHERAL, 1'b0, 1'b1, 1'b1},
        '{10, MODE_OUTPUT, 1'b1, 1'b0, 1'b0, MODE_OUTPUT, 1'b1, 1'b1, 1'b1},
        '{0, MODE_ALTERNATE, 1'b1, 1'b0, 1'b1, MODE_ALTERNATE, 1'b1, 1'b0, 1'b0}
    };

    gpio_bank i_dut (.clk(clk), .reset(reset), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .cfgWrite(cfgWrite), .cfgMode(cfgMode), .outWrite(outWrite),
        .outValue(outValue), .trigKind(trigKind), .irqEnable(irqEnable),
        .irqClear(irqClear), .sleeping(sleeping), .peripheralBusy(peripheralBusy),
        .peripheralOut(peripheralOut), .peripheralOe(peripheralOe), .i2cOut(i2cOut),
        .i2cOe(i2cOe), .netState(netState), .bootDone(bootDone),
        .commandReady(commandReady), .temperatureMonitorCommand(temperatureMonitorCommand),
        .tempMaxReached(tempMaxReached), .tempLineSel(tempLineSel),
        .readValue(readValue), .irqPending(irqPending), .wakeRequest(wakeRequest),
        .modeOf(modeOf));

    pad_board_model i_board (.clk(clk), .reset(reset), .padOut(padOut), .padOe(padOe),
        .drvEn(drvEn), .drvVal(drvVal), .padIn(padIn));

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Step to just after the n-th next rising edge, where inputs change
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Drive a line's pin through a rise, leaving it high
    task automatic rise(input int line);
        drvVal[line] = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs about 120 cycles
    initial begin
        #(40 * 5000);
        fail_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1; sleeping = 1'b0; bootDone = 1'b0; commandReady = 1'b0;
        temperatureMonitorCommand = 1'b0; tempMaxReached = 1'b0; tempLineSel = 5'h00;
        cfgWrite = '0; outWrite = '0; outValue = '0; irqEnable = '0; irqClear = '0;
        drvEn = '0; drvVal = '0; cfgMode = MODE_INPUT; trigKind = TRIG_RISE;
        peripheralBusy = '1; peripheralOut = 17'h00001; peripheralOe = '0;
        i2cOut = '1; i2cOe = '1; netState = NET_OFF;
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        step(1);
        // Power-up state of the bank
        chk("mode0", MODE_ALTERNATE, modeOf[0]);
        chk("mode7", MODE_ALTERNATE, modeOf[7]);
        chk("mode9", MODE_INPUT, modeOf[9]);
        chk("mode26", MODE_PERIPHERAL, modeOf[26]);
        chk("statusOff", 0, padOut[0]);
        chk("readyLow", 0, padOut[7]);
        chk("irqIdle", 0, irqPending);
        // Table-driven configuration cases
        foreach (rows[i]) begin
            drvEn[rows[i].line] = 1'b1;
            drvVal[rows[i].line] = rows[i].pad;
            peripheralBusy[0] = rows[i].busy;
            cfgWrite[rows[i].line] = 1'b1;
            cfgMode = rows[i].mode;
            outWrite[rows[i].line] = 1'b1;
            outValue[rows[i].line] = rows[i].val;
            step(1);
            cfgWrite = '0;
            outWrite = '0;
            step(4);
            chk($sformatf("row%0d mode", i), rows[i].expMode, modeOf[rows[i].line]);
            chk($sformatf("row%0d oe", i), rows[i].expOe, padOe[rows[i].line]);
            chk($sformatf("row%0d out", i), rows[i].expOut, padOut[rows[i].line]);
            chk($sformatf("row%0d rd", i), rows[i].expRd, readValue[rows[i].line]);
        end
        // Call active holds the status indicator high, off brings it low
        netState = NET_CALL;
        step(4);
        chk("statusCall", 1, padOut[0]);
        netState = NET_OFF;
        step(4);
        chk("statusOffAgain", 0, padOut[0]);
        // Ready indicator needs boot finished and command acceptance
        bootDone = 1'b1;
        step(3);
        chk("readyBootOnly", 0, padOut[7]);
        commandReady = 1'b1;
        step(3);
        chk("readyHigh", 1, padOut[7]);
        step(20);
        chk("readyHeld", 1, padOut[7]);
        // Interrupt on line index 5 passes two sync stages first
        drvEn[1] = 1'b1; drvEn[3] = 1'b1; drvEn[5] = 1'b1;
        drvVal[1] = 1'b0; drvVal[3] = 1'b0; drvVal[5] = 1'b0;
        step(5);
        irqEnable[1] = 1'b1; irqEnable[3] = 1'b1; irqEnable[5] = 1'b1;
        step(1);
        rise(5);
        step(2);
        chk("irqEarly", 0, irqPending[5]);
        step(1);
        chk("irqSet", 1, irqPending[5]);
        step(3);
        chk("irqSticky", 1, irqPending[5]);
        irqClear[5] = 1'b1;
        step(1);
        irqClear = '0;
        step(1);
        chk("irqCleared", 0, irqPending[5]);
        // Only wake-capable lines may wake the sleeping device
        sleeping = 1'b1;
        rise(1);
        step(6);
        chk("irqLine2", 1, irqPending[1]);
        chk("noWake", 0, wakeRequest);
        rise(3);
        step(6);
        chk("wakeLine4", 1, wakeRequest);
        // Temperature alarm forces the chosen line high, even an undriven input
        temperatureMonitorCommand = 1'b1;
        tempMaxReached = 1'b1;
        tempLineSel = 5'h03;
        step(3);
        chk("tempOut", 1, padOut[3]);
        chk("tempOe", 1, padOe[3]);
        // Mid-run reset restores the power-up modes and a low ready line
        reset = 1'b1;
        step(1);
        chk("rstMode2", MODE_INPUT, modeOf[2]);
        chk("rstReady", 0, padOut[7]);
        chk("rstIrq", 0, irqPending);
        reset = 1'b0;
        step(2);
        chk("rstReadyBack", 1, padOut[7]);
        give_verdict();
    end
endmodule
